// ===== hdl/plp_planner.sv
/*
 * Preamble length planner: sizes the preamble from channel settings,
 * emits the preamble bit by bit, gates collision sensing and qualifies
 * received packets against the bit sync threshold.
 * Assumes all inputs synchronous to clk_sys and cfg steady on cfg_load.
 * Plan fields are 10 bits wide, so PRE_W may not exceed 10.
 * A cfg_load during a preamble changes the plan in flight.
 */
// Notes on behaviour
// - Preamble timing starts at local packet start.
// - Receiver qualifies after 4 to 7 bits.
// - Post-qualification preamble covers polling delay.
// - Standard mode allows 227-cycle response.
// - Collision detection allows 353-cycle response.
// - Collision resolution allows 430-cycle response.
// - Size from slowest node's MAC clock.
// - Preamble after ignore window meets constraints.
// - Length sums components, plus ignore allowance outside standard mode.
// - Response scaled by squared oscillator tolerance.
// - Credit only seven first-byte bits.
// - Collision sensing after quarter of bit sync.

`include "plp_consts.svh"

module plp_planner
    import plp_pkg::*;
#(
    parameter int PRE_W = 10
) (
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire plp_cfg_t cfg, // Channel configuration
    input wire logic cfg_load, // Pulse: compute a new plan
    input wire logic tx_start, // Pulse: packet starts locally
    input wire logic tx_coll, // Collision report from transceiver
    input wire logic rx_bit_stb, // Pulse: a received bit is ready
    input wire logic rx_bit_ok, // Received bit is valid preamble
    output plp_plan_t plan, // Computed preamble plan
    output logic plan_ok, // Plan computed since reset
    output logic tx_busy, // Preamble in progress
    output logic tx_pre, // Preamble bit being sent
    output logic tx_bit_stb, // Pulse: end of one preamble bit
    output logic tx_data_go, // Pulse: first data byte may start
    output logic coll_sense_en, // Collision sensing armed
    output logic tx_abort, // Pulse: preamble cut by collision
    output logic rx_pkt_valid // Pulse: received packet qualified
);

    // Elaboration check: plan fields hold 10 bits at most
    if (PRE_W < 8 || PRE_W > 10) begin : g_pre_w_bad
        $error("PRE_W must lie in 8..10");
    end

    // Saturation limit of the preamble count, also widened to 64 bits
    localparam logic [PRE_W-1:0] PRE_MAX = {PRE_W{1'b1}};
    localparam logic [63:0] PRE_MAX_64 = 64'(PRE_MAX);

    // Plan state
    plp_plan_t plan_q, plan_d;
    logic plan_ok_q, plan_ok_d;
    plp_mode_t mode_q, mode_d;
    logic [2:0] qual_q, qual_d;
    logic [17:0] bit_cyc_q, bit_cyc_d;

    // Planner arithmetic
    logic [63:0] resp_ref_ns;
    logic [63:0] mac_mhz;
    logic [63:0] bit_ns;
    logic [63:0] tol;
    logic [63:0] resp_ns;
    logic [63:0] adj1_ns;
    logic [63:0] adj2_ns;
    // Response in bits and the preamble sum
    logic [63:0] resp_bits;
    logic [63:0] net_bits;
    logic [63:0] half_sum;
    logic [63:0] total;
    logic [63:0] sense;
    // Bit length and threshold actually used
    logic [63:0] cyc;
    logic [2:0] qual_sel;

    // Plan computation from the loaded configuration
    always_comb begin
        // Reference response time by collision mode
        case (cfg.mode)
            PLP_MODE_CD: resp_ref_ns = `PLP_RESP_CD_NS;
            PLP_MODE_CR: resp_ref_ns = `PLP_RESP_CR_NS;
            default: resp_ref_ns = `PLP_RESP_STD_NS;
        endcase
        // Slowest node sets the response time
        mac_mhz = (cfg.slow_mac_mhz == 8'h00) ? 64'd1 : {56'h0, cfg.slow_mac_mhz};
        resp_ns = (resp_ref_ns * `PLP_REF_MAC_MHZ + mac_mhz - 64'd1) / mac_mhz;
        // Slow receiver against fast sender: tolerance applied twice
        tol = `PLP_PPM_SCALE + {48'h0, cfg.osc_ppm};
        adj1_ns = (resp_ns * tol + `PLP_PPM_SCALE - 64'd1) / `PLP_PPM_SCALE;
        adj2_ns = (adj1_ns * tol + `PLP_PPM_SCALE - 64'd1) / `PLP_PPM_SCALE;
        // Bit time, zero read as one
        bit_ns = (cfg.bit_ns == 20'h0_0000) ? 64'd1 : {44'h0, cfg.bit_ns};
        // Whole bits needed after qualification, rounded up
        resp_bits = (adj2_ns + bit_ns - 64'd1) / bit_ns;
        // First data byte absorbs seven bits, one kept as margin
        net_bits = (resp_bits > `PLP_DATA_CREDIT_BITS) ?
            resp_bits - `PLP_DATA_CREDIT_BITS : 64'd0;
        // Clamp the bit sync threshold into its legal range
        if (cfg.qual_bits < `PLP_QUAL_MIN) begin
            qual_sel = `PLP_QUAL_MIN;
        end else begin
            qual_sel = cfg.qual_bits;
        end
        // Turnaround in half bits, the rest in whole bits
        half_sum = {58'h0, cfg.turn_half} +
            64'd2 * ({60'h0, cfg.missed_bits} + {61'h0, qual_sel} + net_bits);
        total = (half_sum + 64'd1) >> 1;
        // Ignore window comes on top, so the tail still meets all needs
        if (cfg.mode != PLP_MODE_STD) begin
            total = total + {58'h0, cfg.ign_bits};
        end
        // Saturate at what the bit counter can count
        if (total > PRE_MAX_64) begin
            total = PRE_MAX_64;
        end
        // Sensing opens a quarter of the way in, rounded up
        sense = (total + 64'd3) >> `PLP_SENSE_SHIFT;
        // Bit length in system clocks, one at least
        cyc = bit_ns / 64'(`PLP_CLK_PERIOD_NS);
        if (cyc == 64'd0) begin
            cyc = 64'd1;
        end
        // Hold the plan unless a load is asked for
        plan_d = plan_q;
        plan_ok_d = plan_ok_q;
        mode_d = mode_q;
        qual_d = qual_q;
        bit_cyc_d = bit_cyc_q;
        if (cfg_load) begin
            // Saturated above, so the low ten bits are exact
            plan_d.pre_bits = total[9:0];
            if (resp_bits > PRE_MAX_64) begin
                plan_d.resp_bits = 10'(PRE_MAX);
            end else begin
                plan_d.resp_bits = resp_bits[9:0];
            end
            plan_d.sense_bit = sense[9:0];
            plan_ok_d = 1'b1;
            mode_d = cfg.mode;
            qual_d = qual_sel;
            bit_cyc_d = cyc[17:0];
        end
    end

    // Plan registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            plan_q <= '0;
            plan_ok_q <= 1'b0;
            mode_q <= PLP_MODE_STD;
            qual_q <= `PLP_QUAL_MIN;
            bit_cyc_q <= 18'h0_0001;
        end else begin
            plan_q <= plan_d;
            plan_ok_q <= plan_ok_d;
            mode_q <= mode_d;
            qual_q <= qual_d;
            bit_cyc_q <= bit_cyc_d;
        end
    end

    // Transmit sequencer state
    plp_state_t st_q, st_d;
    logic [17:0] cyc_q, cyc_d;
    logic [9:0] bits_q, bits_d;
    logic [9:0] bits_nx;
    logic sense_q, sense_d;
    logic stb_q, stb_d;
    logic go_q, go_d;
    logic abort_q, abort_d;

    // Preamble emission and collision gating
    always_comb begin
        st_d = st_q;
        cyc_d = cyc_q;
        bits_d = bits_q;
        sense_d = sense_q;
        stb_d = 1'b0;
        go_d = 1'b0;
        abort_d = 1'b0;
        // Count of bits sent once the current bit ends
        bits_nx = bits_q + 10'h001;
        case (st_q)
            PLP_ST_IDLE: begin
                // Count from local start, turnaround included
                if (tx_start && plan_ok_q) begin
                    st_d = PLP_ST_PRE;
                    cyc_d = 18'h0_0000;
                    bits_d = '0;
                    sense_d = 1'b0;
                end
            end
            PLP_ST_PRE: begin
                // A collision only counts once sensing is armed
                if (tx_coll && sense_q) begin
                    st_d = PLP_ST_IDLE;
                    abort_d = 1'b1;
                    sense_d = 1'b0;
                end else if (cyc_q == bit_cyc_q - 18'h0_0001) begin
                    // End of one bit time
                    cyc_d = 18'h0_0000;
                    stb_d = 1'b1;
                    bits_d = bits_nx;
                    // Arm sensing a quarter of the way in, never in standard mode
                    if (mode_q != PLP_MODE_STD && bits_nx >= plan_q.sense_bit) begin
                        sense_d = 1'b1;
                    end
                    // Exactly the planned count, then data
                    if (bits_nx == plan_q.pre_bits) begin
                        st_d = PLP_ST_IDLE;
                        go_d = 1'b1;
                        sense_d = 1'b0;
                    end
                end else begin
                    // Still inside the bit
                    cyc_d = cyc_q + 18'h0_0001;
                end
            end
            default: begin
                // Unused state code: back to idle
                st_d = PLP_ST_IDLE;
                sense_d = 1'b0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= PLP_ST_IDLE;
            cyc_q <= 18'h0_0000;
            bits_q <= '0;
            sense_q <= 1'b0;
            stb_q <= 1'b0;
            go_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cyc_q <= cyc_d;
            bits_q <= bits_d;
            sense_q <= sense_d;
            stb_q <= stb_d;
            go_q <= go_d;
            abort_q <= abort_d;
        end
    end

    // Receive qualification state
    logic [2:0] rx_cnt_q, rx_cnt_d;
    logic rx_val_q, rx_val_d;

    // Count consecutive good preamble bits up to the threshold
    always_comb begin
        rx_cnt_d = rx_cnt_q;
        rx_val_d = 1'b0;
        if (rx_bit_stb) begin
            // A bad bit restarts the run
            if (!rx_bit_ok) begin
                rx_cnt_d = 3'h0;
            end else if (rx_cnt_q < qual_q) begin
                // Saturates at the threshold, so a lowered one waits for a bad bit
                rx_cnt_d = rx_cnt_q + 3'h1;
                rx_val_d = (rx_cnt_q + 3'h1 == qual_q);
            end
        end
    end

    // Qualification registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_q <= 3'h0;
            rx_val_q <= 1'b0;
        end else begin
            rx_cnt_q <= rx_cnt_d;
            rx_val_q <= rx_val_d;
        end
    end

    // Plan outputs
    assign plan = plan_q;
    assign plan_ok = plan_ok_q;

    // Transmit outputs, busy and preamble both decoded from the state
    assign tx_busy = (st_q == PLP_ST_PRE);
    assign tx_pre = (st_q == PLP_ST_PRE);
    assign tx_bit_stb = stb_q;
    assign tx_data_go = go_q;
    assign coll_sense_en = sense_q;
    assign tx_abort = abort_q;

    // Receive output
    assign rx_pkt_valid = rx_val_q;

endmodule

// ===== hdl/plp_consts.svh
/*
 * Constants of the preamble length planner: response times, credits,
 * qualification limits and clock timing.
 * Assumes inclusion by hdl/plp_planner.sv only, not by hdl/plp_pkg.sv.
 */
`ifndef PLP_CONSTS_SVH
`define PLP_CONSTS_SVH

// Response allowances in processor cycles
`define PLP_RESP_STD_CYC 227
`define PLP_RESP_CD_CYC 353
`define PLP_RESP_CR_CYC 430

// The same allowances in ns at the reference MAC clock
`define PLP_RESP_STD_NS 64'd136200
`define PLP_RESP_CD_NS 64'd211800
`define PLP_RESP_CR_NS 64'd258000
`define PLP_REF_MAC_MHZ 64'd20

// Oscillator tolerance is in parts per million
`define PLP_PPM_SCALE 64'd1000000

// Data bits that may be credited against the response time
`define PLP_DATA_CREDIT_BITS 64'd7

// Bit sync threshold limits
`define PLP_QUAL_MIN 3'd4
`define PLP_QUAL_MAX 3'd7

// Share of bit sync sent before collision sensing: 1/4 as a shift
`define PLP_SENSE_SHIFT 2

// System clock period in ns
`define PLP_CLK_PERIOD_NS 4

`endif

// ===== hdl/plp_pkg.sv
/*
 * Types of the preamble length planner: modes, states and carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package plp_pkg;

    // Collision handling mode of the channel
    typedef enum logic [1:0] {
        PLP_MODE_STD,
        PLP_MODE_CD,
        PLP_MODE_CR
    } plp_mode_t;

    // Transmit sequencer states
    typedef enum logic [1:0] {
        PLP_ST_IDLE,
        PLP_ST_PRE
    } plp_state_t;

    // Channel configuration, loaded on cfg_load
    typedef struct packed {
        plp_mode_t mode;
        logic [5:0] turn_half;
        logic [3:0] missed_bits;
        logic [2:0] qual_bits;
        logic [5:0] ign_bits;
        logic [15:0] osc_ppm;
        logic [7:0] slow_mac_mhz;
        logic [19:0] bit_ns;
    } plp_cfg_t;

    // Computed plan
    typedef struct packed {
        logic [9:0] pre_bits;
        logic [9:0] resp_bits;
        logic [9:0] sense_bit;
    } plp_plan_t;

endpackage

// ===== tb/plp_planner_asserts.sv
/* Port checker for plp_planner.
   Assumes it is bound to every plp_planner instance. */
module plp_planner_asserts
    import plp_pkg::*;
#(
    parameter int PRE_W = 10
) (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire plp_cfg_t cfg, // Config
    input wire logic cfg_load, // Plan load
    input wire logic tx_start, // Start
    input wire logic tx_coll, // Collision
    input wire logic rx_bit_stb, // Rx strobe
    input wire logic rx_bit_ok, // Rx good bit
    input wire plp_plan_t plan, // Plan
    input wire logic plan_ok, // Plan valid
    input wire logic tx_busy, // Busy
    input wire logic tx_pre, // Preamble
    input wire logic tx_bit_stb, // Bit strobe
    input wire logic tx_data_go, // Data go
    input wire logic coll_sense_en, // Sensing armed
    input wire logic tx_abort, // Abort
    input wire logic rx_pkt_valid // Qualified
);
    // Single clock domain
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_load_sets_ok:
        assert property (cfg_load |=> plan_ok) else $error("plan_ok missing");
    a_plan_holds:
        assert property (!cfg_load |=> $stable(plan)) else $error("plan moved");
    a_start_busy:
        assert property (tx_start && !tx_busy && plan_ok |=> tx_busy) else $error("no busy");
    a_go_last_bit:
        assert property (tx_data_go |-> tx_bit_stb && !tx_busy) else $error("bad go");
    a_stb_in_pre:
        assert property (tx_bit_stb |-> $past(tx_busy)) else $error("stray strobe");
    a_sense_busy:
        assert property (coll_sense_en |-> tx_busy) else $error("sense idle");
    a_coll_aborts:
        assert property (coll_sense_en && tx_coll |=> tx_abort && !tx_busy)
            else $error("no abort");
    a_abort_cause:
        assert property (tx_abort |-> $past(tx_coll) && $past(coll_sense_en))
            else $error("stray abort");
    a_valid_cause:
        assert property (rx_pkt_valid |-> $past(rx_bit_stb) && $past(rx_bit_ok) ##1
            !rx_pkt_valid) else $error("bad valid");
endmodule

bind plp_planner plp_planner_asserts #(.PRE_W(PRE_W)) u_plp_planner_asserts (
    .clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg), .cfg_load(cfg_load),
    .tx_start(tx_start), .tx_coll(tx_coll), .rx_bit_stb(rx_bit_stb),
    .rx_bit_ok(rx_bit_ok), .plan(plan), .plan_ok(plan_ok), .tx_busy(tx_busy),
    .tx_pre(tx_pre), .tx_bit_stb(tx_bit_stb), .tx_data_go(tx_data_go),
    .coll_sense_en(coll_sense_en), .tx_abort(tx_abort), .rx_pkt_valid(rx_pkt_valid));

// ===== tb/plp_node_model.sv
/* Far node: sends a run of good preamble bits, then one bad bit.
   Assumes clk_sys free running and send a one-cycle pulse. */
module plp_node_model (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic send, // Pulse: start a run
    input wire logic [2:0] run_len, // Good bits in run
    output logic rx_bit_stb, // Bit strobe
    output logic rx_bit_ok, // Bit is good
    output logic node_busy // Run in progress
);
    logic [3:0] left_q;
    logic ph_q;
    assign node_busy = (left_q != 4'h0);
    // One bit every other cycle; quality line toggles between bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= 4'h0;
            ph_q <= 1'b0;
            rx_bit_stb <= 1'b0;
            rx_bit_ok <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
            rx_bit_stb <= 1'b0;
            rx_bit_ok <= ~rx_bit_ok;
            if (send) begin
                left_q <= {1'b0, run_len} + 4'h1;
            end else if (node_busy && ph_q) begin
                rx_bit_stb <= 1'b1;
                rx_bit_ok <= (left_q != 4'h1);
                left_q <= left_q - 4'h1;
            end
        end
    end
endmodule

// ===== tb/plp_planner_tb_top.sv
/* Bench for plp_planner: plans, preamble, collision abort, qualification.
   Assumes plp_pkg, the node model and the checker compiled first. */
module plp_planner_tb_top import plp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_load = 1'b0, tx_start = 1'b0, tx_coll = 1'b0, send = 1'b0;
    logic [2:0] run_len = 3'h0;
    plp_cfg_t cfg = '0;
    plp_plan_t plan;
    logic plan_ok, tx_busy, tx_pre, tx_bit_stb, tx_data_go, coll_sense_en;
    logic tx_abort, rx_pkt_valid, rx_bit_stb, rx_bit_ok, node_busy;
    int mismatches = 0, samples_checked = 0, nstb = 0, nval = 0, b;
    plp_planner u_plp_planner (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg),
        .cfg_load(cfg_load), .tx_start(tx_start), .tx_coll(tx_coll),
        .rx_bit_stb(rx_bit_stb), .rx_bit_ok(rx_bit_ok), .plan(plan), .plan_ok(plan_ok),
        .tx_busy(tx_busy), .tx_pre(tx_pre), .tx_bit_stb(tx_bit_stb),
        .tx_data_go(tx_data_go), .coll_sense_en(coll_sense_en), .tx_abort(tx_abort),
        .rx_pkt_valid(rx_pkt_valid));
    plp_node_model u_plp_node_model (.clk_sys(clk_sys), .rst_n(rst_n), .send(send),
        .run_len(run_len), .rx_bit_stb(rx_bit_stb), .rx_bit_ok(rx_bit_ok),
        .node_busy(node_busy));
    // Clock and pulse counters
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        nstb <= nstb + int'(tx_bit_stb === 1'b1);
        nval <= nval + int'(rx_pkt_valid === 1'b1);
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    // Bounded wait: 0 end of preamble, 1 sensing armed, 2 node idle
    task automatic await(input int k);
        int i;
        for (i = 0; i < 9000; i++) begin
            @(negedge clk_sys);
            if (k == 0 && (tx_data_go === 1'b1 || tx_abort === 1'b1)) break;
            if (k == 1 && coll_sense_en === 1'b1) break;
            if (k == 2 && node_busy === 1'b0) break;
        end
        if (i == 9000) begin
            mismatches++;
            complete_run();
        end
    endtask
    // Load a plan: ign 5, turn 1.5 bits, missed 2, slowest MAC 255 MHz
    task automatic load(input plp_mode_t m, input logic [2:0] q, input logic [15:0] ppm,
        input logic [19:0] bns, input logic [9:0] pre, input logic [9:0] rsp);
        @(posedge clk_sys);
        cfg <= '{m, 6'h03, 4'h2, q, 6'h05, ppm, 8'hff, bns};
        cfg_load <= 1'b1;
        @(posedge clk_sys);
        cfg_load <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(plan.pre_bits, pre);
        check(plan.resp_bits, rsp);
        check(plan.sense_bit, (pre + 10'h003) >> 2);
    endtask
    task automatic start();
        b = nstb;
        tx_start <= 1'b1;
        @(posedge clk_sys);
        tx_start <= 1'b0;
        @(negedge clk_sys);
        check({tx_busy, tx_pre}, 10'h003);
    endtask
    task automatic run_rx(input logic [2:0] n, input logic [9:0] exp);
        b = nval;
        send <= 1'b1;
        run_len <= n;
        @(posedge clk_sys);
        send <= 1'b0;
        await(2);
        repeat (3) @(posedge clk_sys);
        check(nval - b, exp);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        check({plan_ok, tx_busy, rx_pkt_valid}, 0);
        check(plan.pre_bits, 0);
        rst_n <= 1'b1;
        // Standard mode, collision report held on but never armed
        load(PLP_MODE_STD, 3'h6, 16'h0000, 20'h0_03e8, 10'h00e, 10'h00b);
        tx_coll <= 1'b1;
        start();
        await(0);
        @(posedge clk_sys);
        tx_coll <= 1'b0;
        @(negedge clk_sys);
        check(nstb - b, 10'h00e);
        $display("test standard done");
        // Oscillator tolerance pushes response over one bit
        load(PLP_MODE_STD, 3'h6, 16'h07d0, 20'h0_29cc, 10'h00a, 10'h002);
        load(PLP_MODE_CR, 3'h6, 16'h0000, 20'h0_03e8, 10'h01d, 10'h015);
        // Detection mode: armed at bit 7, then a collision cuts it
        load(PLP_MODE_CD, 3'h6, 16'h0000, 20'h0_03e8, 10'h019, 10'h011);
        start();
        await(1);
        check(nstb - b + int'(tx_bit_stb), 10'h007);
        @(posedge clk_sys);
        tx_coll <= 1'b1;
        await(0);
        check({tx_abort, tx_busy}, 10'h002);
        @(posedge clk_sys);
        tx_coll <= 1'b0;
        $display("test collision done");
        // Threshold boundaries: one short run, then an exact run
        // Turnaround 1.5, missed 2 and 4 net bits: preamble of q + 8
        for (int q = 4; q < 8; q += 3) begin
            load(PLP_MODE_STD, q[2:0], 16'h0000, 20'h0_03e8, 10'(q + 8), 10'h00b);
            run_rx(q[2:0] - 3'h1, 10'h000);
            run_rx(q[2:0], 10'h001);
        end
        $display("test qualify done");
        complete_run();
    end
endmodule
